/* rtl/pcb_pkg.sv */
// shared constants for the priority pin crossbar
package pcb_pkg;
    // pin and signal counts
    localparam int NPIN = 17;
    localparam int NXP  = 16;
    localparam int NSIG = 17;
    // apb register indices, byte address is four times the index
    localparam logic [7:0] IDX_ROUTE_FIRST  = 8'he1;
    localparam logic [7:0] IDX_ROUTE_SECOND = 8'he2;
    localparam logic [7:0] IDX_SKIP0        = 8'hd4;
    localparam logic [7:0] IDX_SKIP1        = 8'hd5;
    localparam logic [7:0] IDX_INK0         = 8'hf1;
    localparam logic [7:0] IDX_INK1         = 8'hf2;
    localparam logic [7:0] IDX_INK2         = 8'hf3;
    localparam logic [7:0] IDX_DRV0         = 8'ha4;
    localparam logic [7:0] IDX_DRV1         = 8'ha5;
    localparam logic [7:0] IDX_DRV2         = 8'ha6;
    localparam logic [7:0] IDX_LAT0         = 8'h80;
    localparam logic [7:0] IDX_LAT1         = 8'h90;
    localparam logic [7:0] IDX_LAT2         = 8'ha0;
    // reset values
    localparam logic [5:0]  RST_ROUTE_FIRST  = 6'h00;
    localparam logic [7:0]  RST_ROUTE_SECOND = 8'h00;
    localparam logic [15:0] RST_SKIP         = 16'h0000;
    localparam logic [16:0] RST_INK          = 17'h1ffff;
    localparam logic [16:0] RST_DRV          = 17'h00000;
    localparam logic [16:0] RST_LAT          = 17'h1ffff;
    // first routing register fields
    localparam int B_UART   = 0;
    localparam int B_SPI    = 1;
    localparam int B_SMB    = 2;
    localparam int B_SYSCK  = 3;
    localparam int B_CMP    = 4;
    localparam int B_CMPA   = 5;
    localparam int W_ROUTE_FIRST = 6;
    // second routing register fields
    localparam int B_PUOFF  = 7;
    localparam int B_XBON   = 6;
    localparam int B_T1     = 5;
    localparam int B_T0     = 4;
    localparam int B_ECI    = 3;
    localparam int B_UNUSED = 2;
    localparam int B_CHAN   = 0;
    localparam logic [1:0] CHAN_ONE   = 2'h1;
    localparam logic [1:0] CHAN_TWO   = 2'h2;
    localparam logic [1:0] CHAN_THREE = 2'h3;
    // signal indices in priority order
    localparam int S_TX   = 0;
    localparam int S_RX   = 1;
    localparam int S_SCK  = 2;
    localparam int S_MISO = 3;
    localparam int S_MOSI = 4;
    localparam int S_NSS  = 5;
    localparam int S_SDA  = 6;
    localparam int S_SCL  = 7;
    localparam int S_SYSC = 8;
    localparam int S_CMP  = 9;
    localparam int S_CMPA = 10;
    localparam int S_CEX0 = 11;
    localparam int S_CEX1 = 12;
    localparam int S_CEX2 = 13;
    localparam int S_ECI  = 14;
    localparam int S_T0   = 15;
    localparam int S_T1   = 16;
    localparam int S_WALK = 2;
    // fixed uart pins and the port 2 pin
    localparam logic [3:0]  PIN_TX    = 4'h4;
    localparam logic [3:0]  PIN_RX    = 4'h5;
    localparam logic [15:0] UART_MASK = 16'h0030;
    localparam int P2_PIN = 16;
endpackage

/* rtl/pcb_crossbar.sv */
// priority pin crossbar with apb register slave
// Operation
// - enabled resource takes lowest free pin
// - assigned pins skipped for later resources
// - skip-mask pins treated as already assigned
// - uart transmit pin 4, receive pin 5
// - uart claims transmit and receive together
// - smbus data and clock each take the next free pin
// - spi uses four pins only in four-wire
// - leftover pins act as ordinary gpio
// - crossbar-on bit set enables crossbar
// - crossbar off keeps pins plain inputs
// - crossbar off disables all output drivers
// - input-kind one digital, reset digital
// - analog pin: no pullup, driver, receiver
// - drive kind per pin, smbus forced open-drain
// - pullup on open-drain pins unless disabled
// - pullup off while pin drives zero
// - bits five, four route comparator outputs
// - bit three routes inverted system clock
// - bits two, one, zero route smbus, spi, uart
// - upper two first-register bits read zero
// - second register holds pullup, enable, timer, eci
// - two-bit field routes counter channels
module pcb_crossbar (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        spi_four_wire,
    input  wire logic [16:0] per_out,
    input  wire logic [16:0] per_oe,
    output logic      [16:0] per_in,
    input  wire logic [16:0] pin_i,
    output logic      [16:0] pin_o,
    output logic      [16:0] pin_oe,
    output logic      [16:0] pin_pu_en,
    output logic      [16:0] pin_rx_en
);
    logic [5:0]  route_first_q;
    logic [7:0]  route_second_q;
    logic [15:0] skip_q;
    logic [16:0] ink_q;
    logic [16:0] drv_q;
    logic [16:0] lat_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    logic [16:0] pin_o_q;
    logic [16:0] pin_oe_q;
    logic [16:0] pin_pu_q;
    logic [16:0] pin_rx_q;
    logic [16:0] per_in_q;
    logic [16:0] pin_o_d;
    logic [16:0] pin_oe_d;
    logic [16:0] pin_pu_d;
    logic [16:0] pin_rx_d;
    logic [16:0] per_in_d;
    logic [16:0] pad_rd;

    // apb decode
    wire [7:0]  acc_idx   = paddr[9:2];
    wire        acc_align = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    wire        acc_phase = psel && penable && !pready_q;
    wire        acc_done  = psel && penable && pready_q;
    wire        wr_en     = acc_done && pwrite && pstrb[0];
    wire [7:0]  wd        = pwdata[7:0];
    wire        hit_rt1   = acc_align && (acc_idx == pcb_pkg::IDX_ROUTE_FIRST);
    wire        hit_rt2   = acc_align && (acc_idx == pcb_pkg::IDX_ROUTE_SECOND);
    wire        hit_sk0   = acc_align && (acc_idx == pcb_pkg::IDX_SKIP0);
    wire        hit_sk1   = acc_align && (acc_idx == pcb_pkg::IDX_SKIP1);
    wire        hit_ik0   = acc_align && (acc_idx == pcb_pkg::IDX_INK0);
    wire        hit_ik1   = acc_align && (acc_idx == pcb_pkg::IDX_INK1);
    wire        hit_ik2   = acc_align && (acc_idx == pcb_pkg::IDX_INK2);
    wire        hit_dr0   = acc_align && (acc_idx == pcb_pkg::IDX_DRV0);
    wire        hit_dr1   = acc_align && (acc_idx == pcb_pkg::IDX_DRV1);
    wire        hit_dr2   = acc_align && (acc_idx == pcb_pkg::IDX_DRV2);
    wire        hit_lt0   = acc_align && (acc_idx == pcb_pkg::IDX_LAT0);
    wire        hit_lt1   = acc_align && (acc_idx == pcb_pkg::IDX_LAT1);
    wire        hit_lt2   = acc_align && (acc_idx == pcb_pkg::IDX_LAT2);
    wire        hit_any   = hit_rt1 | hit_rt2 | hit_sk0 | hit_sk1 | hit_ik0 | hit_ik1
                          | hit_ik2 | hit_dr0 | hit_dr1 | hit_dr2 | hit_lt0 | hit_lt1
                          | hit_lt2;

    // register fields
    wire        xbar_on    = route_second_q[pcb_pkg::B_XBON];
    wire        pullup_off = route_second_q[pcb_pkg::B_PUOFF];
    wire [1:0]  chan_route = route_second_q[pcb_pkg::B_CHAN +: 2];
    wire        uart_route = route_first_q[pcb_pkg::B_UART];
    wire        spi_route  = route_first_q[pcb_pkg::B_SPI];
    wire        smb_route  = route_first_q[pcb_pkg::B_SMB];

    // enables per signal in priority order
    wire [16:0] sig_en;
    assign sig_en[pcb_pkg::S_TX]   = uart_route;
    assign sig_en[pcb_pkg::S_RX]   = uart_route;
    assign sig_en[pcb_pkg::S_SCK]  = spi_route;
    assign sig_en[pcb_pkg::S_MISO] = spi_route;
    assign sig_en[pcb_pkg::S_MOSI] = spi_route;
    assign sig_en[pcb_pkg::S_NSS]  = spi_route && spi_four_wire;
    assign sig_en[pcb_pkg::S_SDA]  = smb_route;
    assign sig_en[pcb_pkg::S_SCL]  = smb_route;
    assign sig_en[pcb_pkg::S_SYSC] = route_first_q[pcb_pkg::B_SYSCK];
    assign sig_en[pcb_pkg::S_CMP]  = route_first_q[pcb_pkg::B_CMP];
    assign sig_en[pcb_pkg::S_CMPA] = route_first_q[pcb_pkg::B_CMPA];
    assign sig_en[pcb_pkg::S_CEX0] = (chan_route != 2'h0);
    assign sig_en[pcb_pkg::S_CEX1] = (chan_route == pcb_pkg::CHAN_TWO)
                                  || (chan_route == pcb_pkg::CHAN_THREE);
    assign sig_en[pcb_pkg::S_CEX2] = (chan_route == pcb_pkg::CHAN_THREE);
    assign sig_en[pcb_pkg::S_ECI]  = route_second_q[pcb_pkg::B_ECI];
    assign sig_en[pcb_pkg::S_T0]   = route_second_q[pcb_pkg::B_T0];
    assign sig_en[pcb_pkg::S_T1]   = route_second_q[pcb_pkg::B_T1];

    // priority walk, recomputed from the live configuration
    logic [15:0] taken_v;
    logic [15:0] walk_used;
    logic        found_v;
    logic [3:0]  sig_pin  [pcb_pkg::NSIG];
    logic [16:0] sig_ok;
    logic [4:0]  pin_own  [pcb_pkg::NXP];
    logic [15:0] pin_owned;
    logic [15:0] smb_pin_v;

    always_comb begin
        taken_v   = skip_q | (uart_route ? pcb_pkg::UART_MASK : 16'h0000);
        walk_used = 16'h0000;
        found_v   = 1'b0;
        sig_ok    = '0;
        for (int j = 0; j < pcb_pkg::NSIG; j++) begin
            sig_pin[j] = 4'h0;
        end
        sig_pin[pcb_pkg::S_TX] = pcb_pkg::PIN_TX;
        sig_pin[pcb_pkg::S_RX] = pcb_pkg::PIN_RX;
        sig_ok[pcb_pkg::S_TX]  = uart_route;
        sig_ok[pcb_pkg::S_RX]  = uart_route;
        for (int j = pcb_pkg::S_WALK; j < pcb_pkg::NSIG; j++) begin
            found_v = 1'b0;
            if (sig_en[j]) begin
                for (int p = 0; p < pcb_pkg::NXP; p++) begin
                    if (!found_v && !taken_v[p]) begin
                        found_v    = 1'b1;
                        sig_pin[j] = 4'(p);
                    end
                end
            end
            if (found_v) begin
                sig_ok[j]             = 1'b1;
                taken_v[sig_pin[j]]   = 1'b1;
                walk_used[sig_pin[j]] = 1'b1;
            end
        end
        pin_owned = 16'h0000;
        smb_pin_v = 16'h0000;
        for (int p = 0; p < pcb_pkg::NXP; p++) begin
            pin_own[p] = 5'h00;
        end
        for (int j = 0; j < pcb_pkg::NSIG; j++) begin
            if (sig_ok[j]) begin
                pin_owned[sig_pin[j]] = 1'b1;
                pin_own[sig_pin[j]]   = 5'(j);
                if (j == pcb_pkg::S_SDA || j == pcb_pkg::S_SCL) begin
                    smb_pin_v[sig_pin[j]] = 1'b1;
                end
            end
        end
    end

    // per pin drive, pull-up and receiver
    genvar gp;
    generate
        for (gp = 0; gp < pcb_pkg::NPIN; gp++) begin : g_pin
            wire routed;
            wire smb_pin;
            wire src;
            wire req;
            if (gp < pcb_pkg::NXP) begin : g_xp
                assign routed  = xbar_on && pin_owned[gp];
                assign smb_pin = smb_pin_v[gp];
                assign src     = routed ? per_out[pin_own[gp]] : lat_q[gp];
                assign req     = routed ? per_oe[pin_own[gp]] : 1'b1;
            end else begin : g_gpio
                assign routed  = 1'b0;
                assign smb_pin = 1'b0;
                assign src     = lat_q[gp];
                assign req     = 1'b1;
            end
            wire dig    = ink_q[gp];
            wire pp     = drv_q[gp] && !smb_pin;
            wire drv_en = xbar_on && dig && req && (pp || !src);
            assign pin_o_d[gp]  = src;
            assign pin_oe_d[gp] = drv_en;
            assign pin_pu_d[gp] = dig && !pullup_off && (!pp || !xbar_on)
                               && !(drv_en && !src);
            assign pin_rx_d[gp] = dig;
            assign pad_rd[gp]   = dig && pin_i[gp];
        end
    endgenerate

    // peripheral inputs idle high when not routed
    genvar gs;
    generate
        for (gs = 0; gs < pcb_pkg::NSIG; gs++) begin : g_sig
            assign per_in_d[gs] = (xbar_on && sig_ok[gs]) ? pad_rd[sig_pin[gs]] : 1'b1;
        end
    endgenerate

    // read mux
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        unique case (1'b1)
            hit_rt1: rd_byte = {2'h0, route_first_q};
            hit_rt2: rd_byte = route_second_q;
            hit_sk0: rd_byte = skip_q[7:0];
            hit_sk1: rd_byte = skip_q[15:8];
            hit_ik0: rd_byte = ink_q[7:0];
            hit_ik1: rd_byte = ink_q[15:8];
            hit_ik2: rd_byte = {7'h00, ink_q[16]};
            hit_dr0: rd_byte = drv_q[7:0];
            hit_dr1: rd_byte = drv_q[15:8];
            hit_dr2: rd_byte = {7'h00, drv_q[16]};
            hit_lt0: rd_byte = pad_rd[7:0];
            hit_lt1: rd_byte = pad_rd[15:8];
            hit_lt2: rd_byte = {7'h00, pad_rd[16]};
            default: rd_byte = 8'h00;
        endcase
    end

    // apb answer: one wait state, registered
    always_ff @(posedge clk) begin
        if (srst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else begin
            pready_q  <= acc_phase;
            pslverr_q <= acc_phase && !hit_any;
            prdata_q  <= (acc_phase && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    // configuration registers
    always_ff @(posedge clk) begin
        if (srst) begin
            route_first_q  <= pcb_pkg::RST_ROUTE_FIRST;
            route_second_q <= pcb_pkg::RST_ROUTE_SECOND;
            skip_q         <= pcb_pkg::RST_SKIP;
            ink_q          <= pcb_pkg::RST_INK;
            drv_q          <= pcb_pkg::RST_DRV;
            lat_q          <= pcb_pkg::RST_LAT;
        end else if (wr_en) begin
            if (hit_rt1) route_first_q <= wd[pcb_pkg::W_ROUTE_FIRST-1:0];
            if (hit_rt2) route_second_q <= wd & ~(8'h01 << pcb_pkg::B_UNUSED);
            if (hit_sk0) skip_q[7:0] <= wd;
            if (hit_sk1) skip_q[15:8] <= wd;
            if (hit_ik0) ink_q[7:0] <= wd;
            if (hit_ik1) ink_q[15:8] <= wd;
            if (hit_ik2) ink_q[16] <= wd[0];
            if (hit_dr0) drv_q[7:0] <= wd;
            if (hit_dr1) drv_q[15:8] <= wd;
            if (hit_dr2) drv_q[16] <= wd[0];
            if (hit_lt0) lat_q[7:0] <= wd;
            if (hit_lt1) lat_q[15:8] <= wd;
            if (hit_lt2) lat_q[16] <= wd[0];
        end
    end

    // pin and peripheral outputs
    always_ff @(posedge clk) begin
        if (srst) begin
            pin_o_q  <= '0;
            pin_oe_q <= '0;
            pin_pu_q <= '0;
            pin_rx_q <= '0;
            per_in_q <= '1;
        end else begin
            pin_o_q  <= pin_o_d;
            pin_oe_q <= pin_oe_d;
            pin_pu_q <= pin_pu_d;
            pin_rx_q <= pin_rx_d;
            per_in_q <= per_in_d;
        end
    end

    assign prdata    = prdata_q;
    assign pready    = pready_q;
    assign pslverr   = pslverr_q;
    assign pin_o     = pin_o_q;
    assign pin_oe    = pin_oe_q;
    assign pin_pu_en = pin_pu_q;
    assign pin_rx_en = pin_rx_q;
    assign per_in    = per_in_q;

    // lowest free pin for the first walked signal
    logic [3:0] low_free;
    logic       low_ok;
    always_comb begin
        low_free = 4'h0;
        low_ok   = 1'b0;
        for (int p = pcb_pkg::NXP - 1; p >= 0; p--) begin
            if (!(skip_q[p] || (uart_route && pcb_pkg::UART_MASK[p]))) begin
                low_free = 4'(p);
                low_ok   = 1'b1;
            end
        end
    end

    a_spi_lowest_pin: assert property (@(posedge clk) disable iff (srst)
        (spi_route && low_ok) |-> (sig_ok[pcb_pkg::S_SCK] && sig_pin[pcb_pkg::S_SCK] == low_free))
        else $error("spi clock not on lowest free pin");
    a_pin_single_owner: assert property (@(posedge clk) disable iff (srst)
        (spi_route && sig_ok[pcb_pkg::S_MOSI]) |-> (sig_pin[pcb_pkg::S_MOSI] > sig_pin[pcb_pkg::S_MISO]))
        else $error("later resource reused an assigned pin");
    a_skip_never_used: assert property (@(posedge clk) disable iff (srst)
        (walk_used & (skip_q | (uart_route ? pcb_pkg::UART_MASK : 16'h0000))) == 16'h0000)
        else $error("walk landed on a skipped pin");
    a_pins_distinct: assert property (@(posedge clk) disable iff (srst)
        $countones(walk_used) == $countones(sig_ok[pcb_pkg::NSIG-1:pcb_pkg::S_WALK]))
        else $error("two resources share a pin");
    a_uart_fixed_pins: assert property (@(posedge clk) disable iff (srst)
        uart_route |-> (sig_ok[pcb_pkg::S_TX] && sig_ok[pcb_pkg::S_RX]
                        && sig_pin[pcb_pkg::S_TX] == pcb_pkg::PIN_TX
                        && sig_pin[pcb_pkg::S_RX] == pcb_pkg::PIN_RX))
        else $error("uart not on its fixed pins");
    a_nss_four_wire: assert property (@(posedge clk) disable iff (srst)
        !(spi_route && spi_four_wire) |-> !sig_ok[pcb_pkg::S_NSS])
        else $error("slave select routed outside four-wire mode");
    a_off_no_drive: assert property (@(posedge clk) disable iff (srst)
        !xbar_on |=> (pin_oe_q == 17'h00000))
        else $error("driver active while crossbar off");
    a_off_inputs_idle: assert property (@(posedge clk) disable iff (srst)
        !xbar_on |=> (per_in_q == 17'h1ffff))
        else $error("peripheral input routed while crossbar off");
    a_analog_quiet: assert property (@(posedge clk) disable iff (srst)
        1'b1 |=> (((pin_oe_q | pin_pu_q | pin_rx_q) & ~$past(ink_q)) == 17'h00000))
        else $error("analog pin not isolated");
    a_smb_open_drain: assert property (@(posedge clk) disable iff (srst)
        1'b1 |=> ((pin_oe_q & pin_o_q & {1'b0, $past(smb_pin_v, 1)}) == 17'h00000))
        else $error("smbus pin driven high");
    a_pullup_zero_off: assert property (@(posedge clk) disable iff (srst)
        (pin_oe_q & ~pin_o_q & pin_pu_q) == 17'h00000)
        else $error("pull-up on while driving zero");
    a_pullup_open_drain: assert property (@(posedge clk) disable iff (srst)
        1'b1 |=> ((~pin_pu_q & $past(ink_q) & ~$past(drv_q) & ~(pin_oe_q & ~pin_o_q)
                   & {17{!$past(pullup_off)}}) == 17'h00000))
        else $error("open-drain pin lost its pull-up");
    a_reserved_read: assert property (@(posedge clk) disable iff (srst)
        (acc_phase && !pwrite && hit_rt1) |=> (pready_q && prdata_q[7:6] == 2'h0))
        else $error("reserved bits read nonzero");
    a_apb_one_wait: assert property (@(posedge clk) disable iff (srst)
        acc_phase |=> pready_q ##1 !pready_q)
        else $error("apb answer timing broken");

    c_uart_spi_smb: cover property (@(posedge clk) disable iff (srst)
        xbar_on && uart_route && spi_route && smb_route);
    c_skip_walk: cover property (@(posedge clk) disable iff (srst)
        xbar_on && (skip_q != 16'h0000) && sig_ok[pcb_pkg::S_SCK]);
    c_pins_run_out: cover property (@(posedge clk) disable iff (srst)
        sig_en[pcb_pkg::S_T1] && !sig_ok[pcb_pkg::S_T1]);
    c_bad_address: cover property (@(posedge clk) disable iff (srst) pslverr_q);
    c_four_wire_nss: cover property (@(posedge clk) disable iff (srst)
        xbar_on && sig_ok[pcb_pkg::S_NSS]);
endmodule

/* test/pcb_pad_model.sv */
// pad model: resolves each pin from block drive, outside pull-downs and weak pull-ups
module pcb_pad_model (
    input  wire logic        clk,
    input  wire logic [16:0] pin_o,
    input  wire logic [16:0] pin_oe,
    input  wire logic [16:0] pin_pu_en,
    input  wire logic [16:0] ext_low,
    output logic      [16:0] pin_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [16:0] last_q = 17'h00000;
    // a pad nobody drives or pulls floats: show the inverse of its last level
    always_comb begin
        for (int i = 0; i < 17; i++) begin
            if (pin_oe[i])
                pin_i[i] = pin_o[i];
            else if (ext_low[i])
                pin_i[i] = 1'b0;
            else if (pin_pu_en[i])
                pin_i[i] = 1'b1;
            else
                pin_i[i] = ~last_q[i];
        end
    end
    always_ff @(posedge clk) last_q <= pin_i;
endmodule

/* test/priority_pin_crossbar_tb.sv */
// self-checking bench for the priority pin crossbar
module priority_pin_crossbar_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [7:0] rf;
        logic [7:0] rs;
        logic [7:0] sk;
        logic       fw;
        int         k;
        int         p;
    } pcb_row_t;
    // input-only signals: receive, counter clock, timer inputs
    localparam logic [16:0] IN_SIG = 17'h1c002;
    logic        clk           = 1'b0;
    logic        srst          = 1'b1;
    logic        psel          = 1'b0;
    logic        penable       = 1'b0;
    logic        pwrite        = 1'b0;
    logic [11:0] paddr         = 12'h000;
    logic [31:0] pwdata        = 32'h00000000;
    logic [3:0]  pstrb         = 4'hf;
    logic        spi_four_wire = 1'b0;
    logic [16:0] per_out       = 17'h1ffff;
    logic [16:0] per_oe        = 17'h03ffd;
    logic [16:0] ext_low       = 17'h00000;
    logic [31:0] prdata, rd_v;
    logic        pready, pslverr, err_v;
    logic [16:0] per_in, pin_i, pin_o, pin_oe, pin_pu_en, pin_rx_en;
    int          mismatches    = 0;
    int          total_checks  = 0;
    pcb_row_t    r;
    pcb_row_t    rows [20] = '{
        '{8'h07, 8'h40, 8'h0c, 1'b1, pcb_pkg::S_TX, 4},
        '{8'h07, 8'h40, 8'h0c, 1'b1, pcb_pkg::S_SCK, 0},
        '{8'h07, 8'h40, 8'h0c, 1'b1, pcb_pkg::S_MOSI, 6},
        '{8'h07, 8'h40, 8'h0c, 1'b1, pcb_pkg::S_NSS, 7},
        '{8'h07, 8'h40, 8'h0c, 1'b1, pcb_pkg::S_SDA, 8},
        '{8'h07, 8'h40, 8'h0c, 1'b1, pcb_pkg::S_SCL, 9},
        '{8'h07, 8'h40, 8'h0c, 1'b1, pcb_pkg::S_RX, 5},
        '{8'h07, 8'h40, 8'h0c, 1'b0, pcb_pkg::S_SDA, 7},
        '{8'h07, 8'h40, 8'h0c, 1'b0, pcb_pkg::S_SCL, 8},
        '{8'h3e, 8'h40, 8'h00, 1'b0, pcb_pkg::S_SCL, 4},
        '{8'h3e, 8'h40, 8'h00, 1'b0, pcb_pkg::S_SYSC, 5},
        '{8'h3e, 8'h40, 8'h00, 1'b0, pcb_pkg::S_CMPA, 7},
        '{8'h01, 8'h7b, 8'h00, 1'b0, pcb_pkg::S_CEX2, 2},
        '{8'h01, 8'h7b, 8'h00, 1'b0, pcb_pkg::S_ECI, 3},
        '{8'h01, 8'h7b, 8'h00, 1'b0, pcb_pkg::S_T0, 6},
        '{8'h01, 8'h7b, 8'h00, 1'b0, pcb_pkg::S_T1, 7},
        '{8'h00, 8'h41, 8'h00, 1'b0, pcb_pkg::S_CEX1, -1},
        '{8'h00, 8'h42, 8'h00, 1'b0, pcb_pkg::S_CEX1, 1},
        '{8'h01, 8'h40, 8'h30, 1'b0, pcb_pkg::S_TX, 4},
        '{8'h01, 8'h00, 8'h00, 1'b0, pcb_pkg::S_TX, -1}
    };

    always #10 clk = ~clk;

    pcb_crossbar u_pcb_crossbar (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .spi_four_wire(spi_four_wire),
        .per_out(per_out), .per_oe(per_oe), .per_in(per_in), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe(pin_oe), .pin_pu_en(pin_pu_en), .pin_rx_en(pin_rx_en));
    pcb_pad_model u_pcb_pad_model (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe),
        .pin_pu_en(pin_pu_en), .ext_low(ext_low), .pin_i(pin_i));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk_pins(input logic [16:0] got, input logic [16:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // one apb transfer; read data and error are taken at the edge that sees pready
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h000000, wd};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 8);
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            mismatches++;
            end_of_test();
        end
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask

    // crossbar off first, then skips and routes, enable last
    task automatic cfg(input logic [7:0] rf, rs, sk, input logic fw, input int k, p);
        apb(1'b1, pcb_pkg::IDX_ROUTE_SECOND, 8'h00);
        apb(1'b1, pcb_pkg::IDX_SKIP0, sk);
        apb(1'b1, pcb_pkg::IDX_ROUTE_FIRST, rf);
        spi_four_wire <= fw;
        per_out <= ~(17'h1 << k);
        ext_low <= (IN_SIG[k] && p >= 0) ? 17'h1 << p : 17'h0;
        apb(1'b1, pcb_pkg::IDX_ROUTE_SECOND, rs);
        settle();
    endtask

    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        settle();
        chk_pins(pin_rx_en, 17'h1ffff, "reset receivers");
        chk_pins(pin_pu_en, 17'h1ffff, "reset pullups");
        chk_pins(pin_oe, 17'h0, "reset drivers");
        apb(1'b0, pcb_pkg::IDX_ROUTE_FIRST, 8'h00);
        chk_data(rd_v, 32'h0, "route first reset");
        apb(1'b1, pcb_pkg::IDX_ROUTE_FIRST, 8'hff);
        apb(1'b0, pcb_pkg::IDX_ROUTE_FIRST, 8'h00);
        chk_data(rd_v, 32'h3f, "route first bits");
        pstrb <= 4'h0;
        apb(1'b1, pcb_pkg::IDX_ROUTE_FIRST, 8'h00);
        pstrb <= 4'hf;
        apb(1'b0, pcb_pkg::IDX_ROUTE_FIRST, 8'h00);
        chk_data(rd_v, 32'h3f, "strobe off write");
        apb(1'b1, pcb_pkg::IDX_ROUTE_SECOND, 8'h3f);
        apb(1'b0, pcb_pkg::IDX_ROUTE_SECOND, 8'h00);
        chk_data(rd_v, 32'h3b, "route second bits");
        apb(1'b0, 8'h10, 8'h00);
        chk_data({31'h0, err_v}, 32'h1, "unmapped error");
        chk_data(rd_v, 32'h0, "unmapped data");
        apb(1'b1, pcb_pkg::IDX_INK0, 8'hff);
        apb(1'b1, pcb_pkg::IDX_DRV0, 8'hff);
        apb(1'b1, pcb_pkg::IDX_DRV1, 8'hff);
        apb(1'b1, pcb_pkg::IDX_DRV2, 8'h01);
        for (int i = 0; i < 20; i++) begin
            r = rows[i];
            cfg(r.rf, r.rs, r.sk, r.fw, r.k, r.p);
            if (IN_SIG[r.k])
                chk_data({31'h0, per_in[r.k]}, 32'h0, "input route");
            else
                chk_pins(pin_oe & ~pin_o, r.p < 0 ? 17'h0 : 17'h1 << r.p, "route");
        end
        chk_pins(pin_oe, 17'h0, "off drivers");
        chk_pins(per_in, 17'h1ffff, "off inputs");
        apb(1'b1, pcb_pkg::IDX_SKIP1, 8'h01);
        cfg(8'h07, 8'h40, 8'h0c, 1'b1, pcb_pkg::S_SDA, 9);
        chk_pins(pin_oe & 17'h00600, 17'h00200, "smbus open drain");
        apb(1'b1, pcb_pkg::IDX_DRV0, 8'h00);
        apb(1'b1, pcb_pkg::IDX_LAT0, 8'hfd);
        cfg(8'h00, 8'h40, 8'h00, 1'b0, pcb_pkg::S_SDA, -1);
        chk_pins(pin_oe & 17'hf, 17'h2, "gpio low");
        chk_pins(pin_pu_en & 17'hf, 17'hd, "pullup gating");
        apb(1'b1, pcb_pkg::IDX_INK0, 8'hfe);
        apb(1'b1, pcb_pkg::IDX_DRV0, 8'h04);
        settle();
        chk_pins(pin_oe & 17'hf, 17'h6, "analog and push-pull drive");
        chk_pins(pin_pu_en & 17'hf, 17'h8, "analog and push-pull pullup");
        chk_pins(pin_rx_en & 17'hf, 17'he, "analog receiver");
        apb(1'b0, pcb_pkg::IDX_LAT0, 8'h00);
        chk_data(rd_v & 32'h3, 32'h0, "analog and low read");
        apb(1'b1, pcb_pkg::IDX_ROUTE_SECOND, 8'hc0);
        settle();
        chk_pins(pin_pu_en & 17'hf, 17'h0, "pullups disabled");
        // reset in mid-run returns pins and registers to their reset state
        @(posedge clk);
        srst <= 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        settle();
        chk_pins(pin_pu_en, 17'h1ffff, "rerun reset pullups");
        chk_pins(pin_oe, 17'h0, "rerun reset drivers");
        apb(1'b0, pcb_pkg::IDX_ROUTE_FIRST, 8'h00);
        chk_data(rd_v, 32'h0, "rerun route first");
        apb(1'b0, pcb_pkg::IDX_INK2, 8'h00);
        chk_data(rd_v, 32'h1, "port2 input kind reset");
        end_of_test();
    end
endmodule
